/* File: rtl/bst_regs.svh */
// constants of the boundary-scan test port: widths, codes and cell positions
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// instruction register
`define BST_IR_W 2
`define BST_IR_RESET 2'h3
`define BST_IR_CAPTURE 2'h1

// boundary-scan chain length and cell positions
`define BST_BSR_LEN 169
`define BST_N_CTL_IN 24
`define BST_CELL_ACK 24
`define BST_CELL_D_BASE 25
`define BST_D_PINS 16
`define BST_D_STRIDE 3
`define BST_TX_BASE 73
`define BST_TX_GROUPS 4
`define BST_GROUP_PINS 8
`define BST_GROUP_STRIDE 24
`define BST_RX_OFFSET 16

// synchroniser reset images: tck parked high, tms/tdi/trst_n high,
// no drive seen, so no false test clock edge follows reset
`define BST_JT_W 7
`define BST_JT_RESET 7'h78
`define BST_PIN_W 72
`define BST_PIN_RESET 72'h0

`endif

/* File: rtl/bst_pkg.sv */
// types shared by the boundary-scan test port files
package bst_pkg;

  // test controller states
  typedef enum logic [3:0] {
    BST_TLR = 4'h0,
    BST_RTI = 4'h1,
    BST_SEL_DR = 4'h2,
    BST_CAP_DR = 4'h3,
    BST_SHF_DR = 4'h4,
    BST_EX1_DR = 4'h5,
    BST_PAU_DR = 4'h6,
    BST_EX2_DR = 4'h7,
    BST_UPD_DR = 4'h8,
    BST_SEL_IR = 4'h9,
    BST_CAP_IR = 4'hA,
    BST_SHF_IR = 4'hB,
    BST_EX1_IR = 4'hC,
    BST_PAU_IR = 4'hD,
    BST_EX2_IR = 4'hE,
    BST_UPD_IR = 4'hF
  } bst_state_type;

  // decoded instructions
  typedef enum logic [1:0] {
    BST_EXTEST = 2'h0,
    BST_SAMPLE = 2'h1,
    BST_BYPASS = 2'h3
  } bst_instr_type;

  // test port pin levels as seen at the pads
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_jtag_type;

  // which pulled-up test inputs are actively driven from outside
  typedef struct packed {
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_drive_type;

  // one-cycle actions handed to the boundary chain
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
    logic tdi;
  } bst_chain_ctl_type;

endpackage

/* File: rtl/bst_chain.sv */
// boundary-scan shift chain with its update latches
`timescale 1ns/1ps
`include "bst_regs.svh"

module bst_chain #(
  parameter int LEN = `BST_BSR_LEN
) (
  // clock and control
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // actions from the test controller
  input wire bst_pkg::bst_chain_ctl_type ctl,
  // parallel capture values and update latch contents
  input wire logic [LEN-1:0] cap_vec,
  output logic [LEN-1:0] upd_vec,
  // serial output, cell zero
  output logic shift_out
);
  import bst_pkg::*;

  logic [LEN-1:0] sr_reg;

  // capture pin state, then shift toward cell zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sr_reg <= '0;
    end else if (ce) begin
      if (ctl.capture) begin
        sr_reg <= cap_vec;
      end else if (ctl.shift) begin
        sr_reg <= {ctl.tdi, sr_reg[LEN-1:1]};
      end
    end
  end

  // update latches change only at update, so pins stay steady during shift
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      upd_vec <= '0;
    end else if (ce && ctl.update) begin
      upd_vec <= sr_reg;
    end
  end

  assign shift_out = sr_reg[0];

endmodule // bst_chain

/* File: rtl/bst_tap.sv */
// boundary-scan test access port with instruction decode and pin muxing
`timescale 1ns/1ps
`include "bst_regs.svh"

module bst_tap (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // test port pins
  input wire bst_pkg::bst_jtag_type jtag_in,
  input wire bst_pkg::bst_drive_type jtag_driven,
  output logic tdo_out,
  output logic tdo_oe_n,
  // pin levels seen at the input pads
  input wire logic [`BST_N_CTL_IN-1:0] pin_ctl_in,
  input wire logic [31:0] pin_rx_in,
  input wire logic [`BST_D_PINS-1:0] pin_d_in,
  // functional values from the core
  input wire logic core_ack,
  input wire logic [`BST_D_PINS-1:0] core_d_out,
  input wire logic [`BST_D_PINS-1:0] core_d_oe,
  input wire logic [31:0] core_tx,
  input wire logic [31:0] core_tx_oe,
  // pads driven from the scan muxes
  output logic transfer_acknowledge_out,
  output logic [`BST_D_PINS-1:0] pin_d_out,
  output logic [`BST_D_PINS-1:0] pin_d_oe_n,
  output logic [31:0] pin_tx_out,
  output logic [31:0] pin_tx_oe_n,
  // current instruction
  output bst_pkg::bst_instr_type instr_out
);
  import bst_pkg::*;

  // pad pull-up: an undriven input reads high
  function automatic logic pulled(input logic val, input logic drv);
    pulled = drv ? val : 1'b1;
  endfunction

  // instruction decode, used for the chain path and the pin muxes
  function automatic bst_instr_type decode(input logic [`BST_IR_W-1:0] code);
    unique case (code)
      2'h0: decode = BST_EXTEST;
      2'h3: decode = BST_BYPASS;
      2'h1, 2'h2: decode = BST_SAMPLE;
    endcase
  endfunction

  logic [`BST_JT_W-1:0] jt_s1_reg, jt_s2_reg;
  logic [`BST_PIN_W-1:0] pin_s1_reg, pin_s2_reg;
  logic tck_prev_reg;
  logic tck_s, tms_s, tdi_s, trst_n_s;
  logic tck_rise, tck_fall;
  bst_state_type state_reg, state_next;
  logic [`BST_IR_W-1:0] ir_sr_reg;
  logic [`BST_IR_W-1:0] ir_reg;
  logic bypass_reg;
  bst_instr_type instr;
  bst_chain_ctl_type chain_ctl;
  logic [`BST_BSR_LEN-1:0] cap_vec, upd_vec;
  logic chain_out;
  logic [`BST_N_CTL_IN-1:0] ctl_s;
  logic [31:0] rx_s;
  logic [`BST_D_PINS-1:0] d_s;

  // two-stage synchronisers for every pad input
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      jt_s1_reg <= `BST_JT_RESET;
      jt_s2_reg <= `BST_JT_RESET;
      pin_s1_reg <= `BST_PIN_RESET;
      pin_s2_reg <= `BST_PIN_RESET;
    end else if (ce) begin
      jt_s1_reg <= {jtag_in, jtag_driven};
      jt_s2_reg <= jt_s1_reg;
      pin_s1_reg <= {pin_ctl_in, pin_rx_in, pin_d_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // synchronised levels with pull-ups applied
  assign tck_s = jt_s2_reg[6];
  assign tms_s = pulled(jt_s2_reg[5], jt_s2_reg[2]);
  assign tdi_s = pulled(jt_s2_reg[4], jt_s2_reg[1]);
  assign trst_n_s = pulled(jt_s2_reg[3], jt_s2_reg[0]);
  assign {ctl_s, rx_s, d_s} = pin_s2_reg;

  // test clock edges: apart from srst and the test reset pin, all test state moves only on these
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tck_prev_reg <= 1'b1; // matches the parked-high test clock
    end else if (ce) begin
      tck_prev_reg <= tck_s;
    end
  end
  assign tck_rise = tck_s & ~tck_prev_reg;
  assign tck_fall = ~tck_s & tck_prev_reg;

  // controller next state from sampled TMS
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BST_TLR: state_next = tms_s ? BST_TLR : BST_RTI;
      BST_RTI: state_next = tms_s ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: state_next = tms_s ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: state_next = tms_s ? BST_EX1_DR : BST_SHF_DR;
      BST_SHF_DR: state_next = tms_s ? BST_EX1_DR : BST_SHF_DR;
      BST_EX1_DR: state_next = tms_s ? BST_UPD_DR : BST_PAU_DR;
      BST_PAU_DR: state_next = tms_s ? BST_EX2_DR : BST_PAU_DR;
      BST_EX2_DR: state_next = tms_s ? BST_UPD_DR : BST_SHF_DR;
      BST_UPD_DR: state_next = tms_s ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: state_next = tms_s ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR: state_next = tms_s ? BST_EX1_IR : BST_SHF_IR;
      BST_SHF_IR: state_next = tms_s ? BST_EX1_IR : BST_SHF_IR;
      BST_EX1_IR: state_next = tms_s ? BST_UPD_IR : BST_PAU_IR;
      BST_PAU_IR: state_next = tms_s ? BST_EX2_IR : BST_PAU_IR;
      BST_EX2_IR: state_next = tms_s ? BST_UPD_IR : BST_SHF_IR;
      BST_UPD_IR: state_next = tms_s ? BST_SEL_DR : BST_RTI;
    endcase
  end

  // controller state register
  always_ff @(posedge clk_sys) begin
    if (srst || !trst_n_s) begin
      state_reg <= BST_TLR;
    end else if (ce && tck_rise) begin
      state_reg <= state_next;
    end
  end

  // instruction shift stage: capture fixed pattern, shift from TDI
  always_ff @(posedge clk_sys) begin
    if (srst || !trst_n_s) begin
      ir_sr_reg <= `BST_IR_RESET;
    end else if (ce && tck_rise) begin
      if (state_reg == BST_CAP_IR) begin
        ir_sr_reg <= `BST_IR_CAPTURE;
      end else if (state_reg == BST_SHF_IR) begin
        ir_sr_reg <= {tdi_s, ir_sr_reg[`BST_IR_W-1:1]};
      end
    end
  end

  // current instruction: BYPASS after reset, new code at Update-IR
  always_ff @(posedge clk_sys) begin
    if (srst || !trst_n_s) begin
      ir_reg <= `BST_IR_RESET;
    end else if (ce) begin
      if (tck_rise && state_reg == BST_TLR) begin
        ir_reg <= `BST_IR_RESET;
      end else if (tck_fall && state_reg == BST_UPD_IR) begin
        ir_reg <= ir_sr_reg;
      end
    end
  end
  assign instr = decode(ir_reg);

  // one-stage bypass path, cleared at capture
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bypass_reg <= 1'b0;
    end else if (ce && tck_rise && instr == BST_BYPASS) begin
      if (state_reg == BST_CAP_DR) begin
        bypass_reg <= 1'b0;
      end else if (state_reg == BST_SHF_DR) begin
        bypass_reg <= tdi_s;
      end
    end
  end

  // chain actions: only when the boundary register is on the path
  always_comb begin
    chain_ctl.tdi = tdi_s;
    chain_ctl.capture = tck_rise && instr != BST_BYPASS &&
                        state_reg == BST_CAP_DR;
    chain_ctl.shift = tck_rise && instr != BST_BYPASS &&
                      state_reg == BST_SHF_DR;
    chain_ctl.update = tck_fall && instr != BST_BYPASS &&
                       state_reg == BST_UPD_DR;
  end

  // serial output launched on the falling test clock edge
  always_ff @(posedge clk_sys) begin
    if (srst || !trst_n_s) begin
      tdo_out <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (ce && tck_fall) begin
      if (state_reg == BST_SHF_IR) begin
        tdo_out <= ir_sr_reg[0];
        tdo_oe_n <= 1'b0;
      end else if (state_reg == BST_SHF_DR) begin
        tdo_out <= (instr == BST_BYPASS) ? bypass_reg : chain_out;
        tdo_oe_n <= 1'b0;
      end else begin
        tdo_out <= 1'b0;
        tdo_oe_n <= 1'b1;
      end
    end
  end

  // input-only pins: control and address inputs at cells 0 to 23
  assign cap_vec[`BST_N_CTL_IN-1:0] = ctl_s;
  // acknowledge has an output cell only
  assign cap_vec[`BST_CELL_ACK] = core_ack;

  // data bus: control, output, input cell per pin, highest bit first
  genvar gd, gg, gk;
  generate
    for (gd = 0; gd < `BST_D_PINS; gd++) begin : g_dbus
      localparam int C = `BST_CELL_D_BASE + `BST_D_STRIDE * gd;
      localparam int P = `BST_D_PINS - 1 - gd;
      assign cap_vec[C] = core_d_oe[P];
      assign cap_vec[C+1] = core_d_out[P];
      assign cap_vec[C+2] = d_s[P];
    end
    // transmit groups of eight: control and output cells, then receives
    for (gg = 0; gg < `BST_TX_GROUPS; gg++) begin : g_grp
      for (gk = 0; gk < `BST_GROUP_PINS; gk++) begin : g_pin
        localparam int B = `BST_TX_BASE + `BST_GROUP_STRIDE * gg;
        localparam int P = `BST_GROUP_PINS * (`BST_TX_GROUPS - gg) - 1 - gk;
        assign cap_vec[B+2*gk] = core_tx_oe[P];
        assign cap_vec[B+2*gk+1] = core_tx[P];
        assign cap_vec[B+`BST_RX_OFFSET+gk] = rx_s[P];
      end
    end
  endgenerate

  // boundary chain of 169 cells
  bst_chain #(
    .LEN(`BST_BSR_LEN)
  ) u_chain (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .ctl(chain_ctl),
    .cap_vec(cap_vec),
    .upd_vec(upd_vec),
    .shift_out(chain_out)
  );

  // acknowledge pad: latch under EXTEST, core otherwise
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      transfer_acknowledge_out <= 1'b0;
    end else if (ce) begin
      transfer_acknowledge_out <= (instr == BST_EXTEST) ?
          upd_vec[`BST_CELL_ACK] : core_ack;
    end
  end

  // data bus pads; a control cell of one turns the driver on
  generate
    for (gd = 0; gd < `BST_D_PINS; gd++) begin : g_dpad
      localparam int C = `BST_CELL_D_BASE + `BST_D_STRIDE * gd;
      localparam int P = `BST_D_PINS - 1 - gd;
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          pin_d_out[P] <= 1'b0;
          pin_d_oe_n[P] <= 1'b1;
        end else if (ce) begin
          if (instr == BST_EXTEST) begin
            pin_d_out[P] <= upd_vec[C+1];
            pin_d_oe_n[P] <= ~upd_vec[C];
          end else begin
            pin_d_out[P] <= core_d_out[P];
            pin_d_oe_n[P] <= ~core_d_oe[P];
          end
        end
      end
    end
    // transmit pads
    for (gg = 0; gg < `BST_TX_GROUPS; gg++) begin : g_tpad
      for (gk = 0; gk < `BST_GROUP_PINS; gk++) begin : g_pin
        localparam int B = `BST_TX_BASE + `BST_GROUP_STRIDE * gg;
        localparam int P = `BST_GROUP_PINS * (`BST_TX_GROUPS - gg) - 1 - gk;
        always_ff @(posedge clk_sys) begin
          if (srst) begin
            pin_tx_out[P] <= 1'b0;
            pin_tx_oe_n[P] <= 1'b1;
          end else if (ce) begin
            if (instr == BST_EXTEST) begin
              pin_tx_out[P] <= upd_vec[B+2*gk+1];
              pin_tx_oe_n[P] <= ~upd_vec[B+2*gk];
            end else begin
              pin_tx_out[P] <= core_tx[P];
              pin_tx_oe_n[P] <= ~core_tx_oe[P];
            end
          end
        end
      end
    end
  endgenerate

  // instruction visible to the core
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      instr_out <= BST_BYPASS;
    end else if (ce) begin
      instr_out <= instr;
    end
  end

endmodule // bst_tap

/* File: bench/bst_tap_props.sv */
// concurrent checks on the boundary-scan test port pins
`timescale 1ns/1ps
`include "bst_regs.svh"
module bst_tap_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // test port
  input wire bst_pkg::bst_jtag_type jtag_in,
  input wire bst_pkg::bst_drive_type jtag_driven,
  input wire logic tdo_out,
  input wire logic tdo_oe_n,
  // core values and pads
  input wire logic core_ack,
  input wire logic [`BST_D_PINS-1:0] core_d_out,
  input wire logic [`BST_D_PINS-1:0] core_d_oe,
  input wire logic [31:0] core_tx,
  input wire logic transfer_acknowledge_out,
  input wire logic [`BST_D_PINS-1:0] pin_d_out,
  input wire logic [`BST_D_PINS-1:0] pin_d_oe_n,
  input wire logic [31:0] pin_tx_out,
  input wire bst_pkg::bst_instr_type instr_out
);
  import bst_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // test reset pin actively held low; pads follow core outside extest
  logic trst_low;
  logic func_mode;
  assign trst_low = jtag_driven.trst_n && !jtag_in.trst_n;
  assign func_mode = instr_out != BST_EXTEST;
  // checks
  property p_srst;
    $fell(srst) |-> tdo_oe_n && instr_out == BST_BYPASS;
  endproperty
  a_srst: assert property (p_srst) else $error("reset state wrong");
  property p_trst;
    trst_low [*6] |-> tdo_oe_n && instr_out == BST_BYPASS;
  endproperty
  a_trst: assert property (p_trst) else $error("trst no reset");
  property p_oe_start;
    $fell(tdo_oe_n) |-> !$past(jtag_in.tck, 2) && !$past(jtag_in.tck, 3);
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("tdo on rise");
  property p_tdo_hold;
    (jtag_in.tck && jtag_in.trst_n) [*5] |-> $stable(tdo_out) &&
      $stable(tdo_oe_n);
  endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved");
  property p_ir_load;
    $changed(instr_out) && instr_out != BST_BYPASS |->
      !$past(jtag_in.tck, 2);
  endproperty
  a_ir_load: assert property (p_ir_load) else $error("ir load edge");
  property p_pad_d;
    func_mode && $past(func_mode) && !$past(srst) |->
      pin_d_out == $past(core_d_out) && pin_d_oe_n == ~$past(core_d_oe);
  endproperty
  a_pad_d: assert property (p_pad_d) else $error("data pad");
  property p_pad_tx;
    func_mode && $past(func_mode) && !$past(srst) |->
      pin_tx_out == $past(core_tx);
  endproperty
  a_pad_tx: assert property (p_pad_tx) else $error("tx pad");
  property p_ack;
    func_mode && $past(func_mode) && !$past(srst) |->
      transfer_acknowledge_out == $past(core_ack);
  endproperty
  a_ack: assert property (p_ack) else $error("ack pad");
endmodule // bst_tap_props

bind bst_tap bst_tap_props u_props (.clk_sys(clk_sys), .srst(srst),
  .jtag_in(jtag_in), .jtag_driven(jtag_driven), .tdo_out(tdo_out),
  .tdo_oe_n(tdo_oe_n), .core_ack(core_ack), .core_d_out(core_d_out),
  .core_d_oe(core_d_oe), .core_tx(core_tx),
  .transfer_acknowledge_out(transfer_acknowledge_out),
  .pin_d_out(pin_d_out), .pin_d_oe_n(pin_d_oe_n),
  .pin_tx_out(pin_tx_out), .instr_out(instr_out));

/* File: bench/bst_jtag_host.sv */
// external test controller model driving the test port pins
`timescale 1ns/1ps
module bst_jtag_host (
  // clock
  input wire logic clk_sys,
  // test port pins
  output bst_pkg::bst_jtag_type pins,
  output bst_pkg::bst_drive_type drv,
  input wire logic tdo_out,
  input wire logic tdo_oe_n
);
  import bst_pkg::*;
  // idle: test clock parked high, all lines driven high
  initial begin
    pins = 4'hF;
    drv = 3'h7;
  end
  // one 160 ns test clock, tdo read just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk_sys);
    pins.tck <= 1'b0;
    pins.tms <= m;
    pins.tdi <= d;
    repeat (8) @(posedge clk_sys);
    o = tdo_oe_n ? 1'bz : tdo_out;
    pins.tck <= 1'b1;
    repeat (7) @(posedge clk_sys);
  endtask
  // reset pin level and whether tms is driven
  task automatic set_pins(input logic trst_n, input logic tms_drv);
    @(posedge clk_sys);
    pins.trst_n <= trst_n;
    drv.tms <= tms_drv;
  endtask
  // five highs then one low: reset, then idle
  task automatic to_idle();
    logic o;
    for (int i = 0; i < 6; i++) step(i < 5, 1'b1, o);
  endtask
  // instruction scan from idle back to idle
  task automatic ir_scan(input logic [1:0] code, output logic [1:0] cap);
    logic o;
    for (int i = 0; i < 4; i++) step(i < 2, 1'b1, o);
    step(1'b0, code[0], cap[0]);
    step(1'b1, code[1], cap[1]);
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
  // data scan of 169 bits, bit 0 first, back to idle
  task automatic dr_scan(input logic [168:0] din, output logic [168:0] dout);
    logic o;
    for (int i = 0; i < 3; i++) step(i == 0, 1'b1, o);
    for (int i = 0; i < 169; i++) begin
      step(i == 168, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule // bst_jtag_host

/* File: bench/bst_tap_tb.sv */
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`include "bst_regs.svh"
module bst_tap_tb;
  import bst_pkg::*;
  // clock, reset and pins
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  bst_jtag_type jtag_pins;
  bst_drive_type jtag_drv;
  logic tdo_out, tdo_oe_n, core_ack = 1'b0, transfer_acknowledge_out;
  logic [23:0] pin_ctl_in = '0;
  logic [31:0] pin_rx_in = '0, core_tx = '0, core_tx_oe = '0;
  logic [31:0] pin_tx_out, pin_tx_oe_n;
  logic [15:0] pin_d_in = '0, core_d_out = '0, core_d_oe = '0;
  logic [15:0] pin_d_out, pin_d_oe_n;
  bst_instr_type instr_out;
  logic [168:0] pat = {9'h1A5, {5{32'h96C3_5A0F}}};
  int fail_count = 0;
  int n_compared = 0;

  // clock
  initial forever #5 clk_sys = ~clk_sys;

  // device and test controller
  bst_tap u_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .jtag_in(jtag_pins), .jtag_driven(jtag_drv), .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n), .pin_ctl_in(pin_ctl_in), .pin_rx_in(pin_rx_in),
    .pin_d_in(pin_d_in), .core_ack(core_ack), .core_d_out(core_d_out),
    .core_d_oe(core_d_oe), .core_tx(core_tx), .core_tx_oe(core_tx_oe),
    .transfer_acknowledge_out(transfer_acknowledge_out),
    .pin_d_out(pin_d_out), .pin_d_oe_n(pin_d_oe_n),
    .pin_tx_out(pin_tx_out), .pin_tx_oe_n(pin_tx_oe_n),
    .instr_out(instr_out));
  bst_jtag_host u_host (.clk_sys(clk_sys), .pins(jtag_pins),
    .drv(jtag_drv), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // counts, verdict, end of run
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // pad and core values from one word
  task automatic set_core(input logic [31:0] v);
    @(posedge clk_sys);
    core_ack <= v[0];
    core_d_out <= v[15:0];
    core_d_oe <= ~v[15:0];
    core_tx <= v;
    core_tx_oe <= ~v;
    pin_ctl_in <= v[23:0];
    pin_rx_in <= ~v;
    pin_d_in <= v[31:16];
  endtask

  // state after reset
  task automatic t_reset();
    chk(tdo_oe_n, 1'b1);
    chk(instr_out, BST_BYPASS);
  endtask

  // every instruction code, capture pattern and decode
  task automatic t_ir();
    logic [1:0] cap;
    bst_instr_type exp_i;
    for (int c = 0; c < 4; c++) begin
      exp_i = c == 0 ? BST_EXTEST : c == 3 ? BST_BYPASS : BST_SAMPLE;
      u_host.ir_scan(c[1:0], cap);
      chk(cap, 2'h1);
      chk(instr_out, exp_i);
      chk(tdo_oe_n, 1'b1);
    end
  endtask

  // one-stage bypass path
  task automatic t_bypass();
    logic [1:0] cap;
    logic [168:0] o;
    u_host.ir_scan(2'h3, cap);
    u_host.dr_scan(pat, o);
    chk(o[0], 1'b0);
    chk(o[168:137], pat[167:136]);
  endtask

  // sample: captured cells in order, pads untouched
  task automatic t_sample();
    logic [1:0] cap;
    logic [168:0] o;
    set_core(32'h9C3E_5A71);
    u_host.ir_scan(2'h2, cap);
    u_host.dr_scan(pat, o);
    chk(o[0], pin_ctl_in[0]);
    chk(o[23], pin_ctl_in[23]);
    chk(o[24], core_ack);
    chk(o[27], pin_d_in[15]);
    chk(o[72], pin_d_in[0]);
    chk(o[89], pin_rx_in[31]);
    chk(o[168], pin_rx_in[0]);
    chk(pin_tx_out, core_tx);
    chk(pin_d_oe_n ^ core_d_oe, 16'hFFFF);
  endtask

  // preload latches then extest drives them onto the pads
  task automatic t_extest();
    logic [1:0] cap;
    logic [168:0] p;
    logic [168:0] o;
    p = '0;
    p[25] = 1'b1;
    p[26] = 1'b1;
    p[73] = 1'b1;
    p[159] = 1'b1;
    p[160] = 1'b1;
    u_host.dr_scan(p, o);
    u_host.ir_scan(2'h0, cap);
    chk(transfer_acknowledge_out, 1'b0);
    chk(pin_d_oe_n[15:14], 2'h1);
    chk(pin_d_out[15], 1'b1);
    chk(pin_tx_oe_n[31:30], 2'h1);
    chk(pin_tx_out[0], 1'b1);
  endtask

  // test reset pin low clears the instruction
  task automatic t_trst();
    u_host.set_pins(1'b0, 1'b1);
    repeat (10) @(posedge clk_sys);
    chk(instr_out, BST_BYPASS);
    chk(tdo_oe_n, 1'b1);
    u_host.set_pins(1'b1, 1'b1);
    u_host.to_idle();
  endtask

  // undriven tms reads high: five clocks reach reset
  task automatic t_float();
    logic [1:0] cap;
    logic o;
    u_host.ir_scan(2'h0, cap);
    chk(instr_out, BST_EXTEST);
    u_host.set_pins(1'b1, 1'b0);
    for (int i = 0; i < 5; i++) u_host.step(1'b0, 1'b1, o);
    repeat (2) @(posedge clk_sys);
    chk(instr_out, BST_BYPASS);
    u_host.set_pins(1'b1, 1'b1);
    u_host.to_idle();
  endtask

  // enable low freezes the controller: a whole scan is lost
  task automatic t_ce();
    logic [1:0] cap;
    ce <= 1'b0;
    u_host.ir_scan(2'h0, cap);
    chk(instr_out, BST_BYPASS);
    ce <= 1'b1;
    u_host.ir_scan(2'h0, cap);
    chk(instr_out, BST_EXTEST);
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_reset();
    u_host.to_idle();
    t_ir();
    t_bypass();
    t_sample();
    t_extest();
    t_trst();
    t_float();
    t_ce();
    test_done();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    $display("[ERR] %0t run timed out", $time);
    test_done();
  end
endmodule // bst_tap_tb
